// [rtl/irb_pkg.sv]
// package: register map, reset values and carrier types for the iso rx mask and bus-mgmt seeds
package irb_pkg;
    // ==========================================================
    // register offsets (byte addresses)
    localparam logic [7:0]  IRB_OFF_EVT_SET   = 8'ha0;        // receive event set
    localparam logic [7:0]  IRB_OFF_EVT_CLR   = 8'ha4;        // receive event clear, masked read
    localparam logic [7:0]  IRB_OFF_MASK_SET  = 8'ha8;        // receive mask set
    localparam logic [7:0]  IRB_OFF_MASK_CLR  = 8'hac;        // receive mask clear
    localparam logic [7:0]  IRB_OFF_BW_SEED   = 8'hb0;        // initial bandwidth
    localparam logic [7:0]  IRB_OFF_CHHI_SEED = 8'hb4;        // initial channels high
    localparam logic [7:0]  IRB_OFF_CTRL      = 8'hb8;        // software reset control
    // ==========================================================
    // field layouts and reset values
    localparam int          IRB_CTX_N         = 4;            // receive contexts
    localparam int          IRB_BW_W          = 13;           // bandwidth field width
    localparam logic [12:0] IRB_BW_RST        = 13'h1333;     // bandwidth seed reset
    localparam logic [31:0] IRB_CHHI_RST      = 32'hffffffff; // channels-high seed reset
    localparam int          IRB_CTRL_SRST_BIT = 0;            // software reset trigger bit
    localparam logic [1:0]  IRB_RESP_OKAY     = 2'h0;         // axi okay
    localparam logic [1:0]  IRB_RESP_SLVERR   = 2'h2;         // axi slave error
    // ==========================================================
    // carrier: seed values to bus management csrs
    typedef struct packed {
        logic        load;       // one-cycle copy strobe
        logic [12:0] bandwidth;  // bandwidth_available value
        logic [31:0] chan_hi;    // channels_available_hi value
    } irb_csr_load_t;
endpackage

// [rtl/irb_mask_reg.sv]
// set/clear mask register for the receive contexts
`timescale 1ns/10ps
module irb_mask_reg (
    input  wire logic       aclk,
    input  wire logic       rst_ok,     // high: registers run
    input  wire logic       set_we,     // write strobe, set address
    input  wire logic       clr_we,     // write strobe, clear address
    input  wire logic [3:0] wdata,      // low write bits
    output logic      [3:0] mask_q      // current mask
);
    import irb_pkg::*;
    logic [3:0] mask_ff;   // stored mask
    logic [3:0] nxt_mask;  // next mask

    // ==========================================================
    // next state: ones set or clear, zeros leave alone
    always_comb begin
        nxt_mask = mask_ff;
        if (set_we) begin
            nxt_mask = nxt_mask | wdata;
        end
        if (clr_we) begin
            nxt_mask = nxt_mask & ~wdata;
        end
        if (!rst_ok) begin
            nxt_mask = 4'h0;
        end
    end

    // register only
    always_ff @(posedge aclk) begin
        mask_ff <= nxt_mask;
    end
    assign mask_q = mask_ff;

    a_mask_set_bit: assert property (@(posedge aclk) disable iff (!rst_ok)
        set_we && !clr_we |=> ((mask_q & $past(wdata)) == $past(wdata)))
        else $error("mask set did not set bits");
    a_mask_clr_bit: assert property (@(posedge aclk) disable iff (!rst_ok)
        clr_we && !set_we |=> ((mask_q & $past(wdata)) == 4'h0))
        else $error("mask clear did not clear bits");
    a_mask_hold_zero: assert property (@(posedge aclk) disable iff (!rst_ok)
        (set_we || clr_we) |=> ((mask_q & ~$past(wdata)) == ($past(mask_q) & ~$past(wdata))))
        else $error("zero write bits changed mask");
endmodule

// [rtl/irb_regs.sv]
// iso receive mask, receive event and bus-management seed register bank
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/10ps
module irb_regs (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [7:0]             s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [7:0]             s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic [3:0]             rx_ctx_irq,               // context irq, level
    input  wire logic                   global_reset_input,       // global reset, high
    input  wire logic                   host_bus_reset_input,     // host bus reset, high
    input  wire logic                   bus_reset_1394,           // 1394 bus reset, high
    output logic                        iso_receive_summary_irq,  // summary interrupt
    output irb_pkg::irb_csr_load_t      csr_load                  // seeds to csr logic
);
    import irb_pkg::*;

    // ==========================================================
    // state
    logic        aw_ff, nxt_aw;           // write address held
    logic        w_ff, nxt_w;             // write data held
    logic [7:0]  awaddr_ff, nxt_awaddr;   // captured write address
    logic [31:0] wdata_ff, nxt_wdata;     // captured write data
    logic [3:0]  wstrb_ff, nxt_wstrb;     // captured strobes
    logic        bvalid_ff, nxt_bvalid;   // write response pending
    logic [1:0]  bresp_ff, nxt_bresp;     // write response code
    logic        rvalid_ff, nxt_rvalid;   // read response pending
    logic [31:0] rdata_ff, nxt_rdata;     // read data
    logic [1:0]  rresp_ff, nxt_rresp;     // read response code
    logic [3:0]  evt_ff, nxt_evt;         // receive event bits
    logic [3:0]  irq_d_ff, nxt_irq_d;     // context irq delayed, for edges
    logic [12:0] bw_ff, nxt_bw;           // initial_bw_field
    logic [31:0] chhi_ff, nxt_chhi;       // initial_channel_hi_field
    logic        srst_ff, nxt_srst;       // software reset pulse
    logic        trig_d_ff, nxt_trig_d;   // reset trigger level, delayed
    irb_csr_load_t load_ff, nxt_load;     // csr copy output
    logic [3:0]  mask;                    // current receive mask
    logic        do_wr;                   // write commits this cycle
    logic        rst_ok;                  // not in hardware or software reset
    logic        mask_set_we, mask_clr_we;
    logic        trig;                    // any copy trigger level

    // hardware reset and software reset share the register reset
    assign rst_ok = aresetn && !srst_ff;

    // full byte lanes only; partial writes to these registers are ignored
    function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] off,
                                    input logic [3:0] strb);
        wr_hit = (a == off) && (strb == 4'hf);
    endfunction

    // ==========================================================
    // write channel: address and data taken in either order
    assign s_axi_awready = !aw_ff && !bvalid_ff;
    assign s_axi_wready  = !w_ff && !bvalid_ff;
    assign do_wr         = aw_ff && w_ff && !bvalid_ff;

    always_comb begin
        nxt_aw     = aw_ff;
        nxt_w      = w_ff;
        nxt_awaddr = awaddr_ff;
        nxt_wdata  = wdata_ff;
        nxt_wstrb  = wstrb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp  = bresp_ff;
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_aw     = 1'b1;
            nxt_awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_w     = 1'b1;
            nxt_wdata = s_axi_wdata;
            nxt_wstrb = s_axi_wstrb;
        end
        if (do_wr) begin
            nxt_aw     = 1'b0;
            nxt_w      = 1'b0;
            nxt_bvalid = 1'b1;
            case (awaddr_ff)
                IRB_OFF_EVT_SET, IRB_OFF_EVT_CLR, IRB_OFF_MASK_SET, IRB_OFF_MASK_CLR,
                IRB_OFF_BW_SEED, IRB_OFF_CHHI_SEED, IRB_OFF_CTRL: begin
                    nxt_bresp = IRB_RESP_OKAY;
                end
                default: begin
                    nxt_bresp = IRB_RESP_SLVERR; // unmapped
                end
            endcase
        end else if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
        if (!aresetn) begin
            nxt_aw     = 1'b0;
            nxt_w      = 1'b0;
            nxt_awaddr = 8'h00;
            nxt_wdata  = 32'h0;
            nxt_wstrb  = 4'h0;
            nxt_bvalid = 1'b0;
            nxt_bresp  = IRB_RESP_OKAY;
        end
    end

    // ==========================================================
    // read channel: one cycle from address to data
    assign s_axi_arready = !rvalid_ff;

    always_comb begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata  = rdata_ff;
        nxt_rresp  = rresp_ff;
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = IRB_RESP_OKAY;
            case (s_axi_araddr)
                IRB_OFF_EVT_SET: begin
                    nxt_rdata = {28'h0, evt_ff};
                end
                IRB_OFF_EVT_CLR: begin
                    nxt_rdata = {28'h0, evt_ff & mask};
                end
                IRB_OFF_MASK_SET, IRB_OFF_MASK_CLR: begin
                    nxt_rdata = {28'h0, mask};
                end
                IRB_OFF_BW_SEED: begin
                    nxt_rdata = {19'h0, bw_ff};
                end
                IRB_OFF_CHHI_SEED: begin
                    nxt_rdata = chhi_ff;
                end
                IRB_OFF_CTRL: begin
                    nxt_rdata = 32'h0; // trigger bit self-clears
                end
                default: begin
                    nxt_rdata = 32'h0;
                    nxt_rresp = IRB_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
        if (!aresetn) begin
            nxt_rvalid = 1'b0;
            nxt_rdata  = 32'h0;
            nxt_rresp  = IRB_RESP_OKAY;
        end
    end

    // ==========================================================
    // mask register: set and clear strobes
    assign mask_set_we = do_wr && wr_hit(awaddr_ff, IRB_OFF_MASK_SET, wstrb_ff);
    assign mask_clr_we = do_wr && wr_hit(awaddr_ff, IRB_OFF_MASK_CLR, wstrb_ff);

    irb_mask_reg u_mask (
        .aclk   (aclk),
        .rst_ok (rst_ok),
        .set_we (mask_set_we),
        .clr_we (mask_clr_we),
        .wdata  (wdata_ff[IRB_CTX_N-1:0]),
        .mask_q (mask)
    );

    // ==========================================================
    // events: rising edge or set write sets; clear write clears; set wins
    always_comb begin
        nxt_evt   = evt_ff;
        nxt_irq_d = rx_ctx_irq;
        if (do_wr && wr_hit(awaddr_ff, IRB_OFF_EVT_CLR, wstrb_ff)) begin
            nxt_evt = nxt_evt & ~wdata_ff[3:0];
        end
        nxt_evt = nxt_evt | (rx_ctx_irq & ~irq_d_ff);
        if (do_wr && wr_hit(awaddr_ff, IRB_OFF_EVT_SET, wstrb_ff)) begin
            nxt_evt = nxt_evt | wdata_ff[3:0];
        end
        if (!rst_ok) begin
            nxt_evt   = 4'h0;
            nxt_irq_d = 4'h0;
        end
    end

    // summary: bit n of mask gates event n only
    assign iso_receive_summary_irq = |(evt_ff & mask);

    // ==========================================================
    // seeds and software reset
    always_comb begin
        nxt_bw   = bw_ff;
        nxt_chhi = chhi_ff;
        nxt_srst = 1'b0;
        if (do_wr && wr_hit(awaddr_ff, IRB_OFF_BW_SEED, wstrb_ff)) begin
            nxt_bw = wdata_ff[IRB_BW_W-1:0];
        end
        if (do_wr && wr_hit(awaddr_ff, IRB_OFF_CHHI_SEED, wstrb_ff)) begin
            nxt_chhi = wdata_ff;
        end
        if (do_wr && wr_hit(awaddr_ff, IRB_OFF_CTRL, wstrb_ff)) begin
            nxt_srst = wdata_ff[IRB_CTRL_SRST_BIT];
        end
        if (!rst_ok) begin
            nxt_bw   = IRB_BW_RST;
            nxt_chhi = IRB_CHHI_RST;
            nxt_srst = 1'b0;
        end
    end

    // ==========================================================
    // csr copy: one strobe on the falling edge of the combined reset level, when the last source releases
    assign trig = !rst_ok || global_reset_input || host_bus_reset_input || bus_reset_1394;

    always_comb begin
        nxt_trig_d = trig;
        nxt_load   = load_ff;
        nxt_load.load = 1'b0;
        if (trig_d_ff && !trig) begin
            // copy on release so the value is the reset or latest seed
            nxt_load.load      = 1'b1;
            nxt_load.bandwidth = bw_ff;
            nxt_load.chan_hi   = chhi_ff;
        end
        if (!aresetn) begin
            nxt_trig_d = 1'b1;
            nxt_load   = '0;
        end
    end

    // ==========================================================
    // registers only
    always_ff @(posedge aclk) begin
        aw_ff     <= nxt_aw;
        w_ff      <= nxt_w;
        awaddr_ff <= nxt_awaddr;
        wdata_ff  <= nxt_wdata;
        wstrb_ff  <= nxt_wstrb;
        bvalid_ff <= nxt_bvalid;
        bresp_ff  <= nxt_bresp;
        rvalid_ff <= nxt_rvalid;
        rdata_ff  <= nxt_rdata;
        rresp_ff  <= nxt_rresp;
        evt_ff    <= nxt_evt;
        irq_d_ff  <= nxt_irq_d;
        bw_ff     <= nxt_bw;
        chhi_ff   <= nxt_chhi;
        srst_ff   <= nxt_srst;
        trig_d_ff <= nxt_trig_d;
        load_ff   <= nxt_load;
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp  = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata  = rdata_ff;
    assign s_axi_rresp  = rresp_ff;
    assign csr_load     = load_ff;

    // ==========================================================
    // checks
    // pairing spelled out bit by bit, so a crossed mask lane shows up here
    a_summary_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        iso_receive_summary_irq == ((evt_ff[0] && mask[0]) || (evt_ff[1] && mask[1]) ||
                                    (evt_ff[2] && mask[2]) || (evt_ff[3] && mask[3])))
        else $error("summary not gated by mask");
    a_mask_read_same: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && (s_axi_araddr == IRB_OFF_MASK_CLR)
        |=> s_axi_rdata == {28'h0, $past(mask)})
        else $error("mask clear read wrong");
    a_mask_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && (s_axi_araddr == IRB_OFF_MASK_SET)
        |=> s_axi_rdata[31:4] == 28'h0)
        else $error("mask upper bits not zero");
    a_bw_rsvd_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && (s_axi_araddr == IRB_OFF_BW_SEED)
        |=> s_axi_rdata == {19'h0, $past(bw_ff)})
        else $error("bandwidth read wrong");
    a_bw_reset_val: assert property (@(posedge aclk)
        !aresetn |=> bw_ff == IRB_BW_RST && chhi_ff == IRB_CHHI_RST)
        else $error("seed reset value wrong");
    a_bw_bus_reset: assert property (@(posedge aclk) disable iff (!rst_ok)
        bus_reset_1394 && !do_wr |=> $stable(bw_ff))
        else $error("bus reset altered bandwidth");
    sequence s_trig_fall;
        trig ##1 !trig;
    endsequence
    a_csr_copy: assert property (@(posedge aclk) disable iff (!aresetn)
        s_trig_fall |=> csr_load.load && csr_load.bandwidth == $past(bw_ff))
        else $error("bandwidth not copied");
    a_evt_masked_read: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && (s_axi_araddr == IRB_OFF_EVT_CLR)
        |=> s_axi_rdata == {28'h0, $past(evt_ff) & $past(mask)} && $stable(evt_ff)
            || $past(rx_ctx_irq & ~irq_d_ff) != 4'h0 || $past(do_wr))
        else $error("masked event read wrong");
endmodule

// [verification/irb_csr_model.sv]
// far-side model: bus management csrs loaded from the seed carrier
`timescale 1ns/10ps
module irb_csr_model (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire irb_pkg::irb_csr_load_t csr_load,              // seeds and copy strobe
    output logic [12:0]                 bandwidth_available,   // loaded bandwidth csr
    output logic [31:0]                 channels_available_hi, // loaded channels csr
    output logic                        load_seen              // one cycle after a load
);
    import irb_pkg::*;
    // ==========================================================
    // csr capture
    // csrs only move on a load strobe; they are not seeded by our reset, so a
    // missing load after reset release leaves them unknown and fails the compare
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            load_seen <= 1'b0;
        end else begin
            load_seen <= csr_load.load;
            if (csr_load.load) begin
                bandwidth_available   <= csr_load.bandwidth;
                channels_available_hi <= csr_load.chan_hi;
            end
        end
    end
endmodule

// [verification/testbench.sv]
// self-checking bench for the iso rx mask and bus-mgmt seed register bank
`timescale 1ns/10ps
module testbench;
    import irb_pkg::*;
    // ==========================================================
    // signals
    logic        aclk, aresetn;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb, rx_ctx_irq, mask_e;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, irq, load_seen;
    logic [2:0]  trig;                // global, host bus, 1394 bus reset
    logic [12:0] csr_bw, bw_e;
    logic [31:0] csr_ch, r, c;
    irb_csr_load_t csr_load;
    logic [33:0] r_q[$];              // expected {rresp, rdata}
    logic [1:0]  b_q[$];              // expected bresp
    logic [44:0] l_q[$];              // expected {bandwidth, chan_hi} per load
    int          n_mismatch = 0;
    int          checks = 0;
    // ==========================================================
    // design and far-side model
    irb_regs i_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rx_ctx_irq(rx_ctx_irq),
        .global_reset_input(trig[0]), .host_bus_reset_input(trig[1]),
        .bus_reset_1394(trig[2]), .iso_receive_summary_irq(irq), .csr_load(csr_load));
    irb_csr_model i_csr (.aclk(aclk), .aresetn(aresetn), .csr_load(csr_load),
        .bandwidth_available(csr_bw), .channels_available_hi(csr_ch), .load_seen(load_seen));
    // ==========================================================
    // clock, 4 ns period
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    // ==========================================================
    // compare and verdict
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        // a note never matched means a result never showed up
        chk(64'(r_q.size() + b_q.size() + l_q.size()), 64'h0);
        if (n_mismatch == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ==========================================================
    // axi4-lite master tasks; ready lines are sampled at the taking edge
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          input logic [1:0] er);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        b_q.push_back(er);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_wvalid  <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && s_axi_awready) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
        r_q.push_back({er, ed});
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
    endtask
    // reset trigger held for three cycles: one copy is expected at its end
    task automatic pulse(input int k);
        trig <= 3'h1 << k;
        repeat (3) @(posedge aclk);
        trig <= 3'h0;
        repeat (5) @(posedge aclk);
    endtask
    // ==========================================================
    // monitor: oldest note against each result as it appears
    always @(posedge aclk) begin
        if (aresetn && s_axi_rvalid && s_axi_rready && r_q.size() > 0) begin
            chk(64'({s_axi_rresp, s_axi_rdata}), 64'(r_q.pop_front()));
        end
        if (aresetn && s_axi_bvalid && s_axi_bready && b_q.size() > 0) begin
            chk(64'(s_axi_bresp), 64'(b_q.pop_front()));
        end
        if (load_seen && l_q.size() > 0) begin
            chk(64'({csr_bw, csr_ch}), 64'(l_q.pop_front()));
        end else if (load_seen) begin
            // a copy strobe with no note is an extra load
            chk(64'h1, 64'h0);
        end
    end
    // ==========================================================
    // watchdog
    initial begin
        repeat (6000) @(posedge aclk);
        n_mismatch++;
        tally_and_finish();
    end
    // ==========================================================
    // main sequence
    initial begin
        r = $urandom(32'hf7d0c2d5);
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
        {s_axi_bready, s_axi_rready} = 2'h3;
        rx_ctx_irq = 4'h0;
        trig = 3'h0;
        mask_e = 4'h0;
        l_q.push_back({IRB_BW_RST, IRB_CHHI_RST});
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_rd(IRB_OFF_BW_SEED, IRB_RESP_OKAY, {19'h0, IRB_BW_RST});
        axi_rd(IRB_OFF_CHHI_SEED, IRB_RESP_OKAY, IRB_CHHI_RST);
        // random set/clear traffic on the mask, read back at both addresses
        for (int i = 0; i < 6; i++) begin
            r = $urandom;
            axi_wr(IRB_OFF_MASK_SET, r, 4'hf, IRB_RESP_OKAY);
            mask_e = mask_e | r[3:0];
            axi_rd(IRB_OFF_MASK_CLR, IRB_RESP_OKAY, {28'h0, mask_e});
            r = $urandom;
            axi_wr(IRB_OFF_MASK_CLR, r, 4'hf, IRB_RESP_OKAY);
            mask_e = mask_e & ~r[3:0];
            axi_rd(IRB_OFF_MASK_SET, IRB_RESP_OKAY, {28'h0, mask_e});
            axi_rd(IRB_OFF_MASK_CLR, IRB_RESP_OKAY, {28'h0, mask_e});
        end
        // bandwidth seed: reserved bits, partial strobe ignored, unmapped place
        r = $urandom;
        bw_e = r[12:0];
        axi_wr(IRB_OFF_BW_SEED, r, 4'hf, IRB_RESP_OKAY);
        axi_rd(IRB_OFF_BW_SEED, IRB_RESP_OKAY, {19'h0, bw_e});
        axi_wr(IRB_OFF_BW_SEED, ~r, 4'h3, IRB_RESP_OKAY);
        axi_rd(IRB_OFF_BW_SEED, IRB_RESP_OKAY, {19'h0, bw_e});
        axi_wr(8'hc0, r, 4'hf, IRB_RESP_SLVERR);
        axi_rd(8'hc0, IRB_RESP_SLVERR, 32'h0);
        // every context raises, only context n is enabled
        for (int n = 0; n < IRB_CTX_N; n++) begin
            axi_wr(IRB_OFF_MASK_CLR, 32'hf, 4'hf, IRB_RESP_OKAY);
            axi_wr(IRB_OFF_EVT_CLR, 32'hf, 4'hf, IRB_RESP_OKAY);
            rx_ctx_irq <= 4'hf;
            repeat (3) @(posedge aclk);
            rx_ctx_irq <= 4'h0;
            chk(64'(irq), 64'h0);
            axi_wr(IRB_OFF_MASK_SET, 32'h1 << n, 4'hf, IRB_RESP_OKAY);
            @(posedge aclk);
            chk(64'(irq), 64'h1);
            axi_rd(IRB_OFF_EVT_CLR, IRB_RESP_OKAY, 32'h1 << n);
            axi_rd(IRB_OFF_EVT_SET, IRB_RESP_OKAY, 32'hf);
        end
        // set address raises events by write alone; only context 3 is enabled now
        axi_wr(IRB_OFF_EVT_CLR, 32'hf, 4'hf, IRB_RESP_OKAY);
        axi_wr(IRB_OFF_EVT_SET, 32'hd, 4'hf, IRB_RESP_OKAY);
        axi_rd(IRB_OFF_EVT_SET, IRB_RESP_OKAY, 32'hd);
        axi_rd(IRB_OFF_EVT_CLR, IRB_RESP_OKAY, 32'h8);
        // 1394 bus reset copies written seeds and leaves them alone
        r = $urandom;
        c = $urandom;
        bw_e = r[12:0];
        axi_wr(IRB_OFF_BW_SEED, r, 4'hf, IRB_RESP_OKAY);
        axi_wr(IRB_OFF_CHHI_SEED, c, 4'hf, IRB_RESP_OKAY);
        l_q.push_back({bw_e, c});
        pulse(2);
        axi_rd(IRB_OFF_BW_SEED, IRB_RESP_OKAY, {19'h0, bw_e});
        axi_rd(IRB_OFF_CHHI_SEED, IRB_RESP_OKAY, c);
        // global and host bus resets with seeds at their reset values
        axi_wr(IRB_OFF_BW_SEED, {19'h0, IRB_BW_RST}, 4'hf, IRB_RESP_OKAY);
        axi_wr(IRB_OFF_CHHI_SEED, IRB_CHHI_RST, 4'hf, IRB_RESP_OKAY);
        for (int k = 0; k < 2; k++) begin
            l_q.push_back({IRB_BW_RST, IRB_CHHI_RST});
            pulse(k);
        end
        // software reset restores seeds and mask, then copies
        axi_wr(IRB_OFF_BW_SEED, r, 4'hf, IRB_RESP_OKAY);
        axi_wr(IRB_OFF_CHHI_SEED, c, 4'hf, IRB_RESP_OKAY);
        axi_wr(IRB_OFF_MASK_SET, 32'hf, 4'hf, IRB_RESP_OKAY);
        l_q.push_back({IRB_BW_RST, IRB_CHHI_RST});
        axi_wr(IRB_OFF_CTRL, 32'h1 << IRB_CTRL_SRST_BIT, 4'hf, IRB_RESP_OKAY);
        repeat (5) @(posedge aclk);
        axi_rd(IRB_OFF_BW_SEED, IRB_RESP_OKAY, {19'h0, IRB_BW_RST});
        axi_rd(IRB_OFF_MASK_SET, IRB_RESP_OKAY, 32'h0);
        axi_rd(IRB_OFF_CHHI_SEED, IRB_RESP_OKAY, IRB_CHHI_RST);
        repeat (10) @(posedge aclk);
        tally_and_finish();
    end
endmodule
